// ==== core/pcsc_pkg.sv ====
// Purpose: shared constants, field layouts and carriers of the static configuration block
// Assumes: 50 MHz hclk, 32-bit AHB-Lite register access
// Notes:   timer and credit vectors are 36 bits, split over two words each
package pcsc_pkg;

	// clock and time base
	localparam int unsigned CLK_PERIOD_NS   = 20;
	localparam int unsigned US_NS           = 1000;
	localparam int unsigned US_CYCLES       = US_NS / CLK_PERIOD_NS;
	localparam int unsigned L0S_STEP_NS     = 256;
	localparam int unsigned L0S_STEP_CYCLES = (L0S_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned US_DIV_W        = $clog2(US_CYCLES);
	localparam int unsigned STEP_DIV_W      = $clog2(L0S_STEP_CYCLES);

	// documented timer settings, in microseconds
	localparam int unsigned FC_INIT_US    = 17;
	localparam int unsigned FC_UPDATE_US  = 30;
	localparam int unsigned FC_TIMEOUT_US = 200;

	// timer vector layout
	localparam int unsigned VEC_W   = 36;
	localparam int unsigned FCI_LSB = 0;
	localparam int unsigned FCI_W   = 11;
	localparam int unsigned L0S_LSB = 11;
	localparam int unsigned L0S_W   = 5;
	localparam int unsigned FCU_LSB = 12;
	localparam int unsigned FCU_W   = 9;
	localparam int unsigned FCT_LSB = 24;
	localparam int unsigned FCT_W   = 12;

	// credit vector layout
	localparam int unsigned PH_LSB  = 0;
	localparam int unsigned PH_W    = 8;
	localparam int unsigned PD_LSB  = 8;
	localparam int unsigned PD_W    = 12;
	localparam int unsigned NPH_LSB = 20;
	localparam int unsigned NPH_W   = 8;
	localparam int unsigned NPD_LSB = 28;
	localparam int unsigned NPD_W   = 8;
	localparam int unsigned NPD_MIN_ROOM_DW = 1;
	localparam int unsigned CREDIT_DW_SHIFT = 2;

	// base address word layouts
	localparam int unsigned BAR_PREF_BIT = 3;
	localparam int unsigned BAR_64_BIT   = 2;
	localparam int unsigned BAR_IO_BIT   = 0;
	localparam int unsigned ROM_EN_BIT   = 0;
	localparam logic [31:0] BAR_MASK_KEEP = 32'hFFFFFFF0;
	localparam logic [31:0] ROM_MASK_KEEP = 32'hFFFFF800;
	localparam logic [31:0] ROM_WORD_KEEP = 32'hFFFFF801;

	// register map, byte addresses
	localparam logic [7:0] REG_BAR5    = 8'h00;
	localparam logic [7:0] REG_ROM     = 8'h04;
	localparam logic [7:0] REG_TMR_LO  = 8'h08;
	localparam logic [7:0] REG_TMR_HI  = 8'h0C;
	localparam logic [7:0] REG_CRED_LO = 8'h10;
	localparam logic [7:0] REG_CRED_HI = 8'h14;
	localparam logic [7:0] REG_CTRL    = 8'h18;
	localparam logic [7:0] REG_STAT    = 8'h1C;
	localparam int unsigned HI_W       = VEC_W - 32;
	localparam int unsigned CTRL_PREV64_BIT  = 0;
	localparam int unsigned CTRL_LINK_EN_BIT = 1;
	localparam logic [2:0]  HSIZE_WORD       = 3'h2;

	// reset values
	localparam logic [31:0] BAR5_RST = 32'h00000000;
	localparam logic [31:0] ROM_RST  = 32'h00000000;
	localparam logic [1:0]  CTRL_RST = 2'h0;
	localparam logic [VEC_W-1:0] TMR_RST = (VEC_W'(FC_INIT_US) << FCI_LSB)
		| (VEC_W'(FC_UPDATE_US) << FCU_LSB) | (VEC_W'(FC_TIMEOUT_US) << FCT_LSB);
	localparam logic [7:0]  PH_DEF  = 8'h10;
	localparam logic [11:0] PD_DEF  = 12'h040;
	localparam logic [7:0]  NPH_DEF = 8'h10;

	typedef struct packed {
		logic [31:0] mask;
		logic        prefetch;
		logic        is64;
		logic        io;
	} pcsc_bar_s;

	typedef struct packed {
		logic [31:0] mask;
		logic        enable;
	} pcsc_rom_s;

	typedef struct packed {
		logic [7:0]  ph;
		logic [11:0] pd;
		logic [7:0]  nph;
		logic [7:0]  npd;
		logic [11:0] npd_room_dw;
	} pcsc_cred_s;

	function automatic logic [11:0] fld(input logic [VEC_W-1:0] v, input int unsigned lsb,
		input int unsigned w);
		logic [VEC_W-1:0] m;
		m = (VEC_W'(1) << w) - VEC_W'(1);
		return 12'((v >> lsb) & m);
	endfunction

	function automatic pcsc_bar_s bar_decode(input logic [31:0] w, input logic prev64);
		pcsc_bar_s r;
		r.mask     = prev64 ? w : (w & BAR_MASK_KEEP);
		r.prefetch = !prev64 && w[BAR_PREF_BIT];
		r.is64     = !prev64 && w[BAR_64_BIT];
		r.io       = !prev64 && w[BAR_IO_BIT];
		return r;
	endfunction

endpackage

// ==== core/pcsc_interval_timer.sv ====
// Purpose: tick counting interval timer with one-cycle expiry pulse
// Assumes: tick is a one-cycle enable from a divider on hclk
// Notes:   a zero limit acts as one tick
`timescale 1ns/1ps
`default_nettype none
module pcsc_interval_timer #(
	parameter int unsigned W = 12
)(
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic         tick,
	input  wire logic         run,
	input  wire logic         restart,
	input  wire logic [W-1:0] limit,
	output logic              expire
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic         hit_w;
	logic         fire_w;

	assign hit_w  = ({1'b0, cnt_q} + {{W{1'b0}}, 1'b1}) >= {1'b0, limit};
	assign fire_w = run && !restart && tick && hit_w;
	assign cnt_d  = (!run || restart || fire_w) ? '0 : (tick ? cnt_q + W'(1) : cnt_q);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q  <= '0;
			expire <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			expire <= fire_w;
		end
	end
endmodule // pcsc_interval_timer
`default_nettype wire

// ==== core/pcsc_static_config.sv ====
// Purpose: static configuration vectors of an endpoint core, decoded and timed
// Assumes: AHB-Lite single word transfers, link_idle and fc_update_rx from hclk logic
// Notes:   zero wait states, response always OKAY
// Behaviour
// - sixth BAR word: 31..4 mask, 3 prefetchable, 2 64-bit, 1 zero, 0 I/O.
// - previous BAR 64-bit makes all 32 bits upper size mask.
// - ROM word: 31..11 mask, 10..1 zero, bit 0 decode enable.
// - flow control init timer, 11 bits low, 17 us, counted in microsecond ticks.
// - enter L0s after idle for threshold in 256 ns steps; the code steps 13 cycles, 260 ns.
// - update credit timer, 30 us at reset, paces credit updates.
// - flow control time-out check every 200 us without updates.
// - posted header credit from credit vector bits 7..0.
// - posted data credit from 12 bits directly above.
// - non-posted header credit from 8 bits above posted data.
// - non-posted data credit zero, buffer still holds one doubleword.
`timescale 1ns/1ps
`default_nettype none
module pcsc_static_config
	import pcsc_pkg::*;
#(
	parameter logic [7:0]  PH_CRED  = PH_DEF,
	parameter logic [11:0] PD_CRED  = PD_DEF,
	parameter logic [7:0]  NPH_CRED = NPH_DEF
)(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        link_idle,
	input  wire logic        fc_update_rx,
	output pcsc_bar_s        bar5_dec,
	output pcsc_rom_s        rom_dec,
	output pcsc_cred_s       vc0_credit,
	output logic             l0s_active,
	output logic             fc_init_done,
	output logic             fc_update_due,
	output logic             fc_timeout
);
	localparam logic [VEC_W-1:0] CRED_RST = (VEC_W'(PH_CRED) << PH_LSB)
		| (VEC_W'(PD_CRED) << PD_LSB) | (VEC_W'(NPH_CRED) << NPH_LSB);

	logic [31:0]      bar5_word_q;
	logic [31:0]      bar5_word_d;
	logic [31:0]      rom_word_q;
	logic [31:0]      rom_word_d;
	logic [VEC_W-1:0] timer_vector_q;
	logic [VEC_W-1:0] timer_vector_d;
	logic [VEC_W-1:0] vc0_credit_vector_q;
	logic [VEC_W-1:0] vc0_credit_vector_d;
	logic [1:0]       ctrl_q;
	logic [1:0]       ctrl_d;
	logic [7:0]       timeout_cnt_q;
	logic             wr_pend_q;
	logic [7:0]       wr_addr_q;
	logic             addr_ok_w;
	logic             map_ok_w;
	logic             wr_take_w;
	logic             rd_take_w;
	logic             we_bar5_w;
	logic             we_rom_w;
	logic             we_tmr_lo_w;
	logic             we_tmr_hi_w;
	logic             we_cred_lo_w;
	logic             we_cred_hi_w;
	logic             we_ctrl_w;
	logic [31:0]      stat_word_w;
	logic [31:0]      rd_word_w;
	logic             prev64_w;
	logic             link_en_w;

	// bus slave: address phase in one cycle, write lands at the end of the data phase
	assign addr_ok_w = hsel && hready && htrans[1];
	assign map_ok_w  = (haddr[31:8] == 24'h000000);
	assign wr_take_w = addr_ok_w && hwrite && map_ok_w && (hsize == HSIZE_WORD);
	assign rd_take_w = addr_ok_w && !hwrite;

	assign we_bar5_w    = wr_pend_q && (wr_addr_q == REG_BAR5);
	assign we_rom_w     = wr_pend_q && (wr_addr_q == REG_ROM);
	assign we_tmr_lo_w  = wr_pend_q && (wr_addr_q == REG_TMR_LO);
	assign we_tmr_hi_w  = wr_pend_q && (wr_addr_q == REG_TMR_HI);
	assign we_cred_lo_w = wr_pend_q && (wr_addr_q == REG_CRED_LO);
	assign we_cred_hi_w = wr_pend_q && (wr_addr_q == REG_CRED_HI);
	assign we_ctrl_w    = wr_pend_q && (wr_addr_q == REG_CTRL);

	assign bar5_word_d = we_bar5_w ? hwdata : bar5_word_q;
	assign rom_word_d  = we_rom_w ? hwdata : rom_word_q;
	assign timer_vector_d = {we_tmr_hi_w ? hwdata[HI_W-1:0] : timer_vector_q[VEC_W-1:32],
		we_tmr_lo_w ? hwdata : timer_vector_q[31:0]};
	assign vc0_credit_vector_d = {we_cred_hi_w ? hwdata[HI_W-1:0] : vc0_credit_vector_q[VEC_W-1:32],
		we_cred_lo_w ? hwdata : vc0_credit_vector_q[31:0]};
	assign ctrl_d = we_ctrl_w ? hwdata[1:0] : ctrl_q;

	assign prev64_w  = ctrl_q[CTRL_PREV64_BIT];
	assign link_en_w = ctrl_q[CTRL_LINK_EN_BIT];

	assign stat_word_w = {16'h0000, timeout_cnt_q, 6'h00, fc_init_done, l0s_active};

	// reads see the value after a write still in its data phase, so back-to-back works
	assign rd_word_w = !map_ok_w ? 32'h00000000 :
		(haddr[7:0] == REG_BAR5)    ? bar5_word_d :
		(haddr[7:0] == REG_ROM)     ? rom_word_d :
		(haddr[7:0] == REG_TMR_LO)  ? timer_vector_d[31:0] :
		(haddr[7:0] == REG_TMR_HI)  ? {28'h0000000, timer_vector_d[VEC_W-1:32]} :
		(haddr[7:0] == REG_CRED_LO) ? vc0_credit_vector_d[31:0] :
		(haddr[7:0] == REG_CRED_HI) ? {28'h0000000, vc0_credit_vector_d[VEC_W-1:32]} :
		(haddr[7:0] == REG_CTRL)    ? {30'h0, ctrl_d} :
		(haddr[7:0] == REG_STAT)    ? stat_word_w : 32'h00000000;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= 32'h00000000;
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wr_pend_q <= wr_take_w;
			if (wr_take_w) begin
				wr_addr_q <= haddr[7:0];
			end
			if (rd_take_w) begin
				hrdata <= rd_word_w;
			end
		end
	end

	// vectors hold from reset release; software should change them only with the link off
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bar5_word_q         <= BAR5_RST;
			rom_word_q          <= ROM_RST;
			timer_vector_q      <= TMR_RST;
			vc0_credit_vector_q <= CRED_RST;
			ctrl_q              <= CTRL_RST;
		end else begin
			bar5_word_q         <= bar5_word_d;
			rom_word_q          <= rom_word_d;
			timer_vector_q      <= timer_vector_d;
			vc0_credit_vector_q <= vc0_credit_vector_d;
			ctrl_q              <= ctrl_d;
		end
	end

	// decoded configuration, one cycle behind the stored words
	logic [7:0]  npd_w;
	logic [11:0] npd_room_w;

	assign npd_w      = 8'(fld(vc0_credit_vector_q, NPD_LSB, NPD_W));
	assign npd_room_w = (npd_w == 8'h00) ? 12'(NPD_MIN_ROOM_DW) :
		12'(12'(npd_w) << CREDIT_DW_SHIFT);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bar5_dec   <= '0;
			rom_dec    <= '0;
			vc0_credit <= '0;
		end else begin
			bar5_dec               <= bar_decode(bar5_word_q, prev64_w);
			rom_dec.mask           <= rom_word_q & ROM_MASK_KEEP;
			rom_dec.enable         <= rom_word_q[ROM_EN_BIT];
			vc0_credit.ph          <= 8'(fld(vc0_credit_vector_q, PH_LSB, PH_W));
			vc0_credit.pd          <= fld(vc0_credit_vector_q, PD_LSB, PD_W);
			vc0_credit.nph         <= 8'(fld(vc0_credit_vector_q, NPH_LSB, NPH_W));
			vc0_credit.npd         <= npd_w;
			vc0_credit.npd_room_dw <= npd_room_w;
		end
	end

	// time base: one-cycle enables, microsecond and idle step
	logic [US_DIV_W-1:0]   us_div_q;
	logic [STEP_DIV_W-1:0] step_div_q;
	logic                  us_tick_q;
	logic                  step_tick_q;
	logic                  us_wrap_w;
	logic                  step_wrap_w;

	assign us_wrap_w   = (us_div_q == US_DIV_W'(US_CYCLES - 1));
	assign step_wrap_w = (step_div_q == STEP_DIV_W'(L0S_STEP_CYCLES - 1));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			us_div_q    <= '0;
			step_div_q  <= '0;
			us_tick_q   <= 1'b0;
			step_tick_q <= 1'b0;
		end else begin
			us_div_q    <= us_wrap_w ? '0 : us_div_q + US_DIV_W'(1);
			step_div_q  <= step_wrap_w ? '0 : step_div_q + STEP_DIV_W'(1);
			us_tick_q   <= us_wrap_w;
			step_tick_q <= step_wrap_w;
		end
	end

	// link timers
	logic [FCI_W-1:0] init_lim_w;
	logic [L0S_W-1:0] idle_lim_w;
	logic [FCU_W-1:0] upd_lim_w;
	logic [FCT_W-1:0] to_lim_w;
	logic             run_init_w;
	logic             run_upd_w;
	logic             run_idle_w;
	logic             init_exp_w;
	logic             idle_exp_w;

	assign init_lim_w = FCI_W'(fld(timer_vector_q, FCI_LSB, FCI_W));
	assign idle_lim_w = L0S_W'(fld(timer_vector_q, L0S_LSB, L0S_W));
	assign upd_lim_w  = FCU_W'(fld(timer_vector_q, FCU_LSB, FCU_W));
	assign to_lim_w   = fld(timer_vector_q, FCT_LSB, FCT_W);
	assign run_init_w = link_en_w && !fc_init_done;
	assign run_upd_w  = link_en_w && fc_init_done;
	assign run_idle_w = link_en_w && link_idle && !l0s_active;

	pcsc_interval_timer #(.W(FCI_W)) u_init_tmr (
		.hclk    (hclk),
		.hresetn (hresetn),
		.tick    (us_tick_q),
		.run     (run_init_w),
		.restart (1'b0),
		.limit   (init_lim_w),
		.expire  (init_exp_w)
	);

	pcsc_interval_timer #(.W(FCU_W)) u_upd_tmr (
		.hclk    (hclk),
		.hresetn (hresetn),
		.tick    (us_tick_q),
		.run     (run_upd_w),
		.restart (1'b0),
		.limit   (upd_lim_w),
		.expire  (fc_update_due)
	);

	// each received update restarts the check window
	pcsc_interval_timer #(.W(FCT_W)) u_to_tmr (
		.hclk    (hclk),
		.hresetn (hresetn),
		.tick    (us_tick_q),
		.run     (run_upd_w),
		.restart (fc_update_rx),
		.limit   (to_lim_w),
		.expire  (fc_timeout)
	);

	pcsc_interval_timer #(.W(L0S_W)) u_idle_tmr (
		.hclk    (hclk),
		.hresetn (hresetn),
		.tick    (step_tick_q),
		.run     (run_idle_w),
		.restart (!link_idle),
		.limit   (idle_lim_w),
		.expire  (idle_exp_w)
	);

	// activity always wins over a late idle expiry
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fc_init_done  <= 1'b0;
			l0s_active    <= 1'b0;
			timeout_cnt_q <= 8'h00;
		end else begin
			fc_init_done <= link_en_w && (fc_init_done || init_exp_w);
			l0s_active   <= link_en_w && link_idle && (l0s_active || idle_exp_w);
			if (fc_timeout && (timeout_cnt_q != 8'hFF)) begin
				timeout_cnt_q <= timeout_cnt_q + 8'h01;
			end
		end
	end

	// checking helpers
	logic [31:0] init_cyc_q;
	logic [31:0] idle_cyc_q;
	logic [31:0] upd_gap_q;
	logic        upd_seen_q;
	logic [31:0] init_eff_w;
	logic [31:0] idle_eff_w;
	logic [31:0] upd_eff_w;

	assign init_eff_w = (init_lim_w == '0) ? 32'h1 : 32'(init_lim_w);
	assign idle_eff_w = (idle_lim_w == '0) ? 32'h1 : 32'(idle_lim_w);
	assign upd_eff_w  = (upd_lim_w == '0) ? 32'h1 : 32'(upd_lim_w);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			init_cyc_q <= 32'h0;
			idle_cyc_q <= 32'h0;
			upd_gap_q  <= 32'h0;
			upd_seen_q <= 1'b0;
		end else begin
			init_cyc_q <= run_init_w ? init_cyc_q + 32'h1 : 32'h0;
			idle_cyc_q <= (link_en_w && link_idle) ? idle_cyc_q + 32'h1 : 32'h0;
			upd_gap_q  <= !run_upd_w ? 32'h0 : (fc_update_due ? 32'h1 : upd_gap_q + 32'h1);
			upd_seen_q <= run_upd_w && (upd_seen_q || fc_update_due);
		end
	end

	AST_BAR5_FIELDS: assert property (@(posedge hclk) disable iff (!hresetn)
		!prev64_w |=> ({bar5_dec.mask[31:4], bar5_dec.prefetch, bar5_dec.is64, 1'b0, bar5_dec.io}
		== $past(bar5_word_q)) && (bar5_dec.mask[3:0] == 4'h0))
		else $error("bar5 field split wrong");

	AST_BAR5_UPPER: assert property (@(posedge hclk) disable iff (!hresetn)
		prev64_w |=> (bar5_dec.mask == $past(bar5_word_q)) && !bar5_dec.io && !bar5_dec.is64
		&& !bar5_dec.prefetch)
		else $error("bar5 not whole upper mask");

	AST_ROM_FIELDS: assert property (@(posedge hclk) disable iff (!hresetn)
		hresetn |=> ({rom_dec.mask[31:1], rom_dec.enable} == ($past(rom_word_q) & ROM_WORD_KEEP))
		&& !rom_dec.mask[0])
		else $error("rom word split wrong");

	AST_FC_INIT_TIME: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(fc_init_done) |-> (init_cyc_q >= (init_eff_w - 32'h1) * US_CYCLES)
		&& (init_cyc_q <= init_eff_w * US_CYCLES + 32'h2))
		else $error("init timer out of range");

	AST_L0S_ENTRY: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(l0s_active) |-> $past(link_idle)
		&& (idle_cyc_q >= (idle_eff_w - 32'h1) * L0S_STEP_CYCLES))
		else $error("l0s entered too early");

	AST_L0S_EXIT: assert property (@(posedge hclk) disable iff (!hresetn)
		!link_idle |=> !l0s_active)
		else $error("l0s held while active");

	AST_FC_UPDATE_PACE: assert property (@(posedge hclk) disable iff (!hresetn)
		fc_update_due && upd_seen_q && $stable(upd_lim_w) |-> upd_gap_q == upd_eff_w * US_CYCLES)
		else $error("update pacing wrong");

	AST_FC_TIMEOUT_RESTART: assert property (@(posedge hclk) disable iff (!hresetn)
		fc_update_rx |=> !fc_timeout)
		else $error("timeout despite update");

	AST_CRED_PH: assert property (@(posedge hclk) disable iff (!hresetn)
		hresetn |=> vc0_credit.ph == 8'($past(vc0_credit_vector_q)))
		else $error("posted header credit wrong");

	AST_CRED_PD: assert property (@(posedge hclk) disable iff (!hresetn)
		hresetn |=> vc0_credit.pd == 12'($past(vc0_credit_vector_q) >> PD_LSB))
		else $error("posted data credit wrong");

	AST_CRED_NPH: assert property (@(posedge hclk) disable iff (!hresetn)
		hresetn |=> vc0_credit.nph == 8'($past(vc0_credit_vector_q) >> NPH_LSB))
		else $error("non-posted header credit wrong");

	AST_NPD_ROOM: assert property (@(posedge hclk) disable iff (!hresetn)
		hresetn |=> (vc0_credit.npd_room_dw >= 12'(NPD_MIN_ROOM_DW))
		&& ((vc0_credit.npd == 8'h00) == (vc0_credit.npd_room_dw == 12'(NPD_MIN_ROOM_DW))))
		else $error("non-posted data room missing");

endmodule // pcsc_static_config
`default_nettype wire

// ==== sim/pcsc_user_model.sv ====
// Purpose: user logic beside the block, driving link idle and credit updates
// Assumes: same hclk domain, requests from the bench are levels
// Notes:   updates are single-cycle pulses every GAP cycles while enabled
`timescale 1ns/1ps
`default_nettype none
module pcsc_user_model #(
	parameter int unsigned GAP = 100
)(
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic idle_req,
	input  wire logic upd_on,
	output logic      link_idle,
	output logic      fc_update_rx
);
	logic [7:0] gap_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gap_q <= 8'h00;
			link_idle <= 1'b0;
			fc_update_rx <= 1'b0;
		end else begin
			link_idle <= idle_req;
			// keep the window alive well inside the time-out interval
			gap_q <= (upd_on && gap_q != 8'(GAP - 1)) ? gap_q + 8'h01 : 8'h00;
			fc_update_rx <= upd_on && gap_q == 8'(GAP - 1);
		end
	end
endmodule // pcsc_user_model
`default_nettype wire

// ==== sim/testbench.sv ====
// Purpose: self-checking bench of the static configuration block
// Assumes: zero wait-state slave, bus hready taken from hreadyout
// Notes:   timer fields are written small so the run stays short
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("BAD %s exp %0h got %0h", nm, e, g); end end
module testbench
	import pcsc_pkg::*;
;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = HSIZE_WORD;
	logic        hreadyout, hresp, link_idle, fc_update_rx, idle_req = 1'b0, upd_on = 1'b0;
	logic        l0s_active, fc_init_done, fc_update_due, fc_timeout;
	pcsc_bar_s   bar5_dec;
	pcsc_rom_s   rom_dec;
	pcsc_cred_s  vc0_credit;
	int          n_mismatch = 0, num_checks = 0;
	logic [31:0] rd;
	int          n;
	always #10 hclk = ~hclk;
	pcsc_static_config dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link_idle(link_idle),
		.fc_update_rx(fc_update_rx), .bar5_dec(bar5_dec), .rom_dec(rom_dec),
		.vc0_credit(vc0_credit), .l0s_active(l0s_active), .fc_init_done(fc_init_done),
		.fc_update_due(fc_update_due), .fc_timeout(fc_timeout));
	pcsc_user_model far (.hclk(hclk), .hresetn(hresetn), .idle_req(idle_req),
		.upd_on(upd_on), .link_idle(link_idle), .fc_update_rx(fc_update_rx));
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic wait_ready;
		int k;
		k = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			if (++k > 50) begin n_mismatch++; tally_and_finish(); end
			@(posedge hclk);
		end
	endtask
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [2:0] sz, output logic [31:0] q);
		hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= wr; hsize <= sz;
		wait_ready();
		htrans <= 2'h0; hwdata <= d;
		wait_ready();
		q = hrdata;
		`CHK("hresp", 1'b0, hresp)
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, HSIZE_WORD, rd);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0, HSIZE_WORD, rd);
		`CHK("read", e, rd)
	endtask
	// flag picked by number: 0 init done, 1 update due, 2 timeout, 3 l0s
	function automatic logic flag_of(input int sel);
		return (sel == 0) ? fc_init_done : (sel == 1) ? fc_update_due :
			(sel == 2) ? fc_timeout : l0s_active;
	endfunction
	// counts cycles until a flag rises; running out ends the run
	task automatic wait_hi(input int sel, input int lim, output int c);
		c = 0;
		#1;
		while (flag_of(sel) !== 1'b1) begin
			if (++c > lim) begin n_mismatch++; tally_and_finish(); end
			@(posedge hclk); #1;
		end
	endtask
	task automatic t_reset;
		rd_chk(REG_TMR_LO, 32'hC801E011);
		rd_chk(REG_TMR_HI, 32'h0);
		rd_chk(REG_CRED_LO, 32'h01004010);
		`CHK("npd", 8'h00, vc0_credit.npd)
		`CHK("room", 12'h001, vc0_credit.npd_room_dw)
		rd_chk(8'h40, 32'h0);
	endtask
	task automatic t_bar;
		wr(REG_BAR5, 32'hABCDE00D);
		xfer(1'b1, REG_ROM, 32'hFFFFFFFF, 3'h0, rd);
		wr(8'h40, 32'hFFFFFFFF);
		repeat (2) @(posedge hclk);
		#1;
		`CHK("bar mask", 32'hABCDE000, bar5_dec.mask)
		`CHK("bar flags", 3'b111, {bar5_dec.prefetch, bar5_dec.is64, bar5_dec.io})
		`CHK("rom byte write", 1'b0, rom_dec.enable)
		rd_chk(8'h40, 32'h0);
		wr(REG_CTRL, 32'h1);
		wr(REG_ROM, 32'hFFFFFFFF);
		repeat (2) @(posedge hclk);
		#1;
		`CHK("bar64 mask", 32'hABCDE00D, bar5_dec.mask)
		`CHK("bar64 flags", 3'b000, {bar5_dec.prefetch, bar5_dec.is64, bar5_dec.io})
		`CHK("rom mask", 32'hFFFFF800, rom_dec.mask)
		`CHK("rom en", 1'b1, rom_dec.enable)
	endtask
	task automatic t_cred;
		wr(REG_CRED_LO, 32'h12345678);
		wr(REG_CRED_HI, 32'h3);
		repeat (2) @(posedge hclk);
		#1;
		`CHK("ph", 8'h78, vc0_credit.ph)
		`CHK("pd", 12'h456, vc0_credit.pd)
		`CHK("nph", 8'h23, vc0_credit.nph)
		`CHK("room", 12'h0C4, vc0_credit.npd_room_dw)
		`CHK("npd", 8'h31, vc0_credit.npd)
		wr(REG_CRED_HI, 32'h0);
		wr(REG_CRED_LO, 32'h02345678);
		repeat (2) @(posedge hclk);
		#1;
		`CHK("room zero", 12'h001, vc0_credit.npd_room_dw)
	endtask
	task automatic t_timers;
		logic [31:0] s0;
		// vectors change only while the link is off
		wr(REG_CTRL, 32'h0);
		wr(REG_TMR_LO, 32'h04003002);
		wr(REG_TMR_HI, 32'h0);
		wr(REG_CTRL, 32'h2);
		wait_hi(0, 110, n);
		`CHK("init time", 1'b1, n >= 51 && n <= 102)
		wait_hi(1, 160, n);
		@(posedge hclk);
		wait_hi(1, 160, n);
		`CHK("update gap", 1'b1, n >= 148 && n <= 151)
		// one more time-out lands before the first update, so snapshot after it
		upd_on <= 1'b1;
		repeat (120) @(posedge hclk);
		xfer(1'b0, REG_STAT, 32'h0, HSIZE_WORD, s0);
		`CHK("timeouts seen", 1'b1, s0[15:8] != 8'h00)
		repeat (800) @(posedge hclk);
		rd_chk(REG_STAT, {16'h0000, s0[15:8], 8'h02});
		upd_on <= 1'b0;
		wait_hi(2, 320, n);
		`CHK("timeout", 1'b1, n >= 150 && n <= 201)
		// threshold field reads 6 after the write above
		idle_req <= 1'b1;
		wait_hi(3, 90, n);
		`CHK("l0s entry", 1'b1, n >= 64 && n <= 81)
		rd_chk(REG_STAT, {16'h0000, s0[15:8] + 8'h01, 8'h03});
		idle_req <= 1'b0;
		repeat (3) @(posedge hclk);
		#1;
		`CHK("l0s exit", 1'b0, l0s_active)
		wr(REG_CTRL, 32'h0);
		repeat (2) @(posedge hclk);
		#1;
		`CHK("init clear", 1'b0, fc_init_done)
	endtask
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_bar();
		t_cred();
		t_timers();
		tally_and_finish();
	end
endmodule // testbench
`default_nettype wire
